// file: src/otp_cmd_cfg.svh
// constants of the otp-read, go-to-secure and hard-stop command decoder
`ifndef OTP_CMD_CFG_SVH
`define OTP_CMD_CFG_SVH

// application command bytes
`define CMD_OTP_READ 8'h82
`define CMD_GO_SECURE 8'h84
`define CMD_HARD_STOP 8'h85

// target address layout: {2'b11, programmable bits, hardwired bit}
`define ADDR_FIXED_HI 2'h3
`define ADDR_GENERAL_CALL 7'h00
`define ADDR_RW_BIT 0

// response layout
`define OTP_BYTE_COUNT 6
`define OTP_LAST_INDEX 3'h5
`define RESP_FILL_BYTE 8'hFF
`define RESP_ADDR_TOP 3'h7

// reset values
`define RESET_BYTE 8'h00
`define RESET_POS 16'h0000

`endif

// file: src/otp_cmd_pkg.sv
// types used by the command decoder core; the frame parser declares its own
package otp_cmd_pkg;

  // hard stop sequence, gray coded along idle -> wait -> copy; copy -> idle flips both bits
  typedef enum logic [1:0] {
    STOP_IDLE = 2'b00,
    STOP_WAIT = 2'b01,
    STOP_COPY = 2'b11
  } stop_state_t;

  typedef logic [7:0] byte_t;

endpackage

// file: src/frame_if.sv
// frame level events passed from the byte parser to the command core
`timescale 1ns/1ps
interface frame_if;
  logic addrHit;
  logic broadcast;
  logic readFrame;
  logic cmdStrobe;
  logic [7:0] cmdByte;
  logic rdStrobe;
  logic [2:0] rdIndex;

  modport parser (
    output addrHit,
    output broadcast,
    output readFrame,
    output cmdStrobe,
    output cmdByte,
    output rdStrobe,
    output rdIndex
  );

  modport core (
    input addrHit,
    input broadcast,
    input readFrame,
    input cmdStrobe,
    input cmdByte,
    input rdStrobe,
    input rdIndex
  );
endinterface

// file: src/frame_bytes.sv
// frame parser: address match, command byte capture and read phase count
`timescale 1ns/1ps
`include "otp_cmd_cfg.svh"
module frame_bytes (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // byte layer events
  input wire logic busStart,
  input wire logic busStop,
  input wire logic rxStrobe,
  input wire logic [7:0] rxByte,
  input wire logic txReq,
  // own address, already synchronised
  input wire logic [3:0] otpAddrBits,
  input wire logic hardwiredAddressBit,
  // events to the core
  frame_if.parser frame
);

  typedef struct packed {
    logic [1:0] byteIdx;
    logic addrHit;
    logic broadcast;
    logic readFrame;
    logic cmdStrobe;
    logic [7:0] cmdByte;
    logic rdStrobe;
    logic [2:0] rdIndex;
  } parse_t;

  parse_t st;
  parse_t next_st;
  logic [6:0] ownAddr;

  // the address is rebuilt every cycle so a late otp load is picked up
  assign ownAddr = {`ADDR_FIXED_HI, otpAddrBits, hardwiredAddressBit};

  // frame tracking; strobes last one cycle
  always_comb
  begin
    next_st = st;
    next_st.cmdStrobe = 1'b0;
    next_st.rdStrobe = 1'b0;
    // phase count moves on after the strobe, so rdIndex names the strobed phase;
    // it saturates so a long read stays on fill and never wraps back to the echo
    if (st.rdStrobe && st.rdIndex != 3'h7)
      next_st.rdIndex = st.rdIndex + 3'h1;
    if (busStart || busStop)
    begin
      next_st.byteIdx = 2'h0;
      next_st.addrHit = 1'b0;
      next_st.broadcast = 1'b0;
      next_st.readFrame = 1'b0;
      next_st.rdIndex = 3'h0;
    end
    else if (rxStrobe && st.byteIdx == 2'h0)
    begin
      next_st.byteIdx = 2'h1;
      next_st.readFrame = rxByte[`ADDR_RW_BIT];
      // foreign addresses leave addrHit and broadcast low, so the frame is ignored
      next_st.addrHit = rxByte[7:1] == ownAddr;
      next_st.broadcast = rxByte[7:1] == `ADDR_GENERAL_CALL && !rxByte[`ADDR_RW_BIT];
    end
    else if (rxStrobe && st.byteIdx == 2'h1 && !st.readFrame)
    begin
      next_st.byteIdx = 2'h2;
      // only the first data byte is a command; later bytes are dropped
      next_st.cmdStrobe = st.addrHit || st.broadcast;
      next_st.cmdByte = rxByte;
    end
    if (txReq && st.addrHit && st.readFrame && !busStart && !busStop)
    begin
      next_st.rdStrobe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign frame.addrHit = st.addrHit;
  assign frame.broadcast = st.broadcast;
  assign frame.readFrame = st.readFrame;
  assign frame.cmdStrobe = st.cmdStrobe;
  assign frame.cmdByte = st.cmdByte;
  assign frame.rdStrobe = st.rdStrobe;
  assign frame.rdIndex = st.rdIndex;

endmodule

// file: src/otp_stop_cmd.sv
// command core: otp read-back, go-to-secure request and hard stop sequence
`timescale 1ns/1ps
`include "otp_cmd_cfg.svh"

// How it works
// - an addressed otp-read command byte arms a pending otp response
// - next read frame returns otp bytes 0x00 to 0x05 in ascending order
// - go-to-secure command requests a motion to the 11-bit secure position
// - go-to-secure is accepted both on own address and on general call
// - go-to-secure is dropped when arbitration forbids it, causing no motion
// - a coil fault triggers the hard stop internally and enters shutdown
// - hard stop while moving sets step loss, cleared by short status read
// - once stopped, actual position is copied into target position
// - hard stop command runs the same stop sequence as the fault path
// - own address is 11, four otp address bits, then the hardwired bit
module otp_stop_cmd (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // byte layer of the bus target, same clock
  input wire logic busStart,
  input wire logic busStop,
  input wire logic rxStrobe,
  input wire logic [7:0] rxByte,
  input wire logic txReq,
  output logic [7:0] txByte,
  output logic addrAck,
  // pins, asynchronous
  input wire logic hardwiredAddressBit,
  input wire logic coilFaultX,
  input wire logic coilFaultY,
  // one-time-programmable memory contents
  input wire logic [3:0] otpAddrBits,
  input wire logic [47:0] otpBytes,
  // motion side, same clock
  input wire logic [10:0] securePosition,
  input wire logic secureAllowed,
  input wire logic motorMoving,
  input wire logic [15:0] actualPosition,
  input wire logic shortStatusRead,
  output logic secureReq,
  output logic [10:0] secureTarget,
  output logic hardStopReq,
  output logic targetLoad,
  output logic [15:0] targetPosition,
  output logic stepLossFlag,
  output logic shutdownMode
);

  typedef struct packed {
    logic [1:0] hwSync;
    logic [1:0] faultXSync;
    logic [1:0] faultYSync;
    logic otpPending;
    logic otpServing;
    otp_cmd_pkg::byte_t txByte;
    logic secureReq;
    logic [10:0] secureTarget;
    logic hardStopReq;
    otp_cmd_pkg::stop_state_t stopState;
    logic targetLoad;
    logic [15:0] targetPosition;
    logic stepLossFlag;
    logic shutdownMode;
  } core_t;

  core_t st;
  core_t next_st;
  frame_if frame ();

  logic coilFault;
  logic cmdOwn;
  logic goSecureCmd;
  logic hardStopCmd;
  logic stopTrigger;

  // picks one otp byte; index 1 is otp address 0x00
  function automatic otp_cmd_pkg::byte_t otp_pick(input logic [47:0] mem,
                                                  input logic [2:0] idx);
    otp_cmd_pkg::byte_t b;
    b = `RESP_FILL_BYTE;
    for (int i = 0; i < `OTP_BYTE_COUNT; i++)
    begin
      if (idx == 3'(i + 1))
        b = mem[i * 8 +: 8];
    end
    return b;
  endfunction

  frame_bytes u_frame (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .busStart(busStart),
    .busStop(busStop),
    .rxStrobe(rxStrobe),
    .rxByte(rxByte),
    .txReq(txReq),
    .otpAddrBits(otpAddrBits),
    .hardwiredAddressBit(st.hwSync[1]),
    .frame(frame)
  );

  // decode of the captured command byte
  assign coilFault = st.faultXSync[1] || st.faultYSync[1];
  assign cmdOwn = frame.cmdStrobe && frame.addrHit;
  assign goSecureCmd = frame.cmdStrobe && frame.cmdByte == `CMD_GO_SECURE;
  assign hardStopCmd = cmdOwn && frame.cmdByte == `CMD_HARD_STOP;
  // a fault only triggers once; shutdown then holds until reset
  assign stopTrigger = hardStopCmd || (coilFault && !st.shutdownMode);

  // one next-state process for all of the core's state
  always_comb
  begin
    next_st = st;
    next_st.secureReq = 1'b0;
    next_st.hardStopReq = 1'b0;
    next_st.targetLoad = 1'b0;
    // pins pass two flip-flops; only stage 1 is read by logic
    next_st.hwSync = {st.hwSync[0], hardwiredAddressBit};
    next_st.faultXSync = {st.faultXSync[0], coilFaultX};
    next_st.faultYSync = {st.faultYSync[0], coilFaultY};

    // otp read command arms the response for the next read frame
    if (cmdOwn && frame.cmdByte == `CMD_OTP_READ)
      next_st.otpPending = 1'b1;

    // a read frame consumes the pending response
    if (busStart || busStop)
      next_st.otpServing = 1'b0;
    if (frame.addrHit && frame.readFrame && st.otpPending && !st.otpServing)
    begin
      next_st.otpServing = 1'b1;
      next_st.otpPending = 1'b0;
    end

    // transmit byte: the address echo first, then otp 0x00..0x05, then fill
    if (frame.rdStrobe)
    begin
      if (!st.otpServing)
        next_st.txByte = `RESP_FILL_BYTE;
      else if (frame.rdIndex == 3'h0)
        next_st.txByte = {`RESP_ADDR_TOP, otpAddrBits, st.hwSync[1]};
      else
        next_st.txByte = otp_pick(otpBytes, frame.rdIndex);
    end

    // go-to-secure is dropped while stopping, shut down or forbidden
    if (goSecureCmd && secureAllowed && !st.shutdownMode
        && st.stopState == otp_cmd_pkg::STOP_IDLE && !stopTrigger)
    begin
      next_st.secureReq = 1'b1;
      next_st.secureTarget = securePosition;
    end

    // hard stop sequence, common to command and fault
    case (st.stopState)
      otp_cmd_pkg::STOP_IDLE:
      begin
        if (stopTrigger)
        begin
          next_st.hardStopReq = 1'b1;
          next_st.stopState = otp_cmd_pkg::STOP_WAIT;
        end
      end
      otp_cmd_pkg::STOP_WAIT:
      begin
        // waits for the motion side to report standstill
        if (!motorMoving)
          next_st.stopState = otp_cmd_pkg::STOP_COPY;
      end
      otp_cmd_pkg::STOP_COPY:
      begin
        next_st.targetPosition = actualPosition;
        next_st.targetLoad = 1'b1;
        next_st.stopState = otp_cmd_pkg::STOP_IDLE;
      end
      default:
        next_st.stopState = otp_cmd_pkg::STOP_IDLE;
    endcase
    // a stop while already stopping restarts nothing but still reasserts
    if (stopTrigger && st.stopState != otp_cmd_pkg::STOP_IDLE)
      next_st.hardStopReq = 1'b1;

    if (coilFault)
      next_st.shutdownMode = 1'b1;

    // set wins over the status-read clear so no step loss is missed
    if (shortStatusRead)
      next_st.stepLossFlag = 1'b0;
    if (stopTrigger && motorMoving)
      next_st.stepLossFlag = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.txByte <= `RESP_FILL_BYTE;
      st.targetPosition <= `RESET_POS;
      st.stopState <= otp_cmd_pkg::STOP_IDLE;
    end
    else
      st <= next_st;
  end

  // outputs straight from state, ack follows the address match
  assign addrAck = frame.addrHit || frame.broadcast;
  assign txByte = st.txByte;
  assign secureReq = st.secureReq;
  assign secureTarget = st.secureTarget;
  assign hardStopReq = st.hardStopReq;
  assign targetLoad = st.targetLoad;
  assign targetPosition = st.targetPosition;
  assign stepLossFlag = st.stepLossFlag;
  assign shutdownMode = st.shutdownMode;

endmodule

// file: sim/otp_stop_cmd_assertions.sv
// port-level checks of the command decoder
`timescale 1ns/1ps
module otp_stop_cmd_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // inputs
  input wire logic coilFaultX,
  input wire logic coilFaultY,
  input wire logic [10:0] securePosition,
  input wire logic secureAllowed,
  input wire logic motorMoving,
  input wire logic [15:0] actualPosition,
  input wire logic shortStatusRead,
  // outputs
  input wire logic secureReq,
  input wire logic [10:0] secureTarget,
  input wire logic hardStopReq,
  input wire logic targetLoad,
  input wire logic [15:0] targetPosition,
  input wire logic stepLossFlag,
  input wire logic shutdownMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // a stop request, then the motor seen at rest
  sequence haltSeen;
    hardStopReq ##1 !motorMoving [*2];
  endsequence
  // a fault held long enough to pass the two-stage synchroniser
  sequence faultHeld;
    !shutdownMode ##1 (coilFaultX || coilFaultY) [*4];
  endsequence
  fault_shutdown_a: assert property (faultHeld |-> ##[0:2] shutdownMode)
    else $error("fault gave no shutdown");
  shutdown_stop_a: assert property ($rose(shutdownMode) |-> hardStopReq)
    else $error("shutdown without stop");
  loss_on_stop_a: assert property (hardStopReq && $past(motorMoving) |-> stepLossFlag)
    else $error("step loss not set");
  loss_clear_a: assert property (shortStatusRead ##1 !hardStopReq |-> !stepLossFlag)
    else $error("step loss not cleared");
  halt_copy_a: assert property (haltSeen |-> ##[0:3] targetLoad)
    else $error("no target load after stop");
  copy_value_a: assert property (targetLoad |-> targetPosition == $past(actualPosition))
    else $error("wrong stop position");
  secure_target_a: assert property (secureReq |-> secureTarget == $past(securePosition))
    else $error("wrong secure target");
  secure_allowed_a: assert property (secureReq |-> $past(secureAllowed) && !shutdownMode)
    else $error("secure move not allowed");
endmodule

bind otp_stop_cmd otp_stop_cmd_assertions chk (.sys_clk, .nrst, .coilFaultX, .coilFaultY,
  .securePosition, .secureAllowed, .motorMoving, .actualPosition, .shortStatusRead,
  .secureReq, .secureTarget, .hardStopReq, .targetLoad, .targetPosition, .stepLossFlag,
  .shutdownMode);

// file: sim/i2c_ctrl_model.sv
// bus controller model driving the byte layer of the target
`timescale 1ns/1ps
module i2c_ctrl_model (
  // clock
  input wire logic sys_clk,
  // byte layer
  output logic busStart = 1'b0,
  output logic busStop = 1'b0,
  output logic rxStrobe = 1'b0,
  output logic [7:0] rxByte = 8'h00,
  output logic txReq = 1'b0,
  input wire logic [7:0] txByte
);
  int gap = 0; // extra cycles before a read phase, for a slow controller
  // start or stop condition as a one-cycle pulse
  task automatic edge_ev(input logic stp);
    @(posedge sys_clk);
    busStart <= !stp;
    busStop <= stp;
    @(posedge sys_clk);
    busStart <= 1'b0;
    busStop <= 1'b0;
  endtask
  // released data is inverted so a stale byte cannot pass as fresh
  task automatic put(input logic [7:0] v);
    @(posedge sys_clk);
    rxStrobe <= 1'b1;
    rxByte <= v;
    @(posedge sys_clk);
    rxStrobe <= 1'b0;
    rxByte <= ~v;
  endtask
  // one read phase; five cycles apart keeps txReq spacing legal
  task automatic get(output logic [7:0] v);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    txReq <= 1'b1;
    @(posedge sys_clk);
    txReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    v = txByte;
  endtask
  // whole write frame, to one target or to all
  task automatic wframe(input logic [7:0] a, input logic [7:0] c);
    edge_ev(1'b0);
    put(a);
    put(c);
    edge_ev(1'b1);
  endtask
endmodule

// file: sim/otp_stop_cmd_tb_top.sv
// self-checking bench of the command decoder
`timescale 1ns/1ps
module otp_stop_cmd_tb_top;
  localparam logic [47:0] OTP = 48'h6655_4433_2211;
  logic sys_clk, nrst, hardwiredAddressBit;
  logic coilFaultX, coilFaultY, secureAllowed;
  logic motorMoving, shortStatusRead;
  logic [15:0] actualPosition, targetPosition;
  logic [3:0] otpAddrBits;
  logic [47:0] otpBytes;
  logic [10:0] securePosition;
  logic busStart, busStop, rxStrobe, txReq, addrAck, secureReq, hardStopReq;
  logic targetLoad, stepLossFlag, shutdownMode;
  logic [7:0] rxByte, txByte, rd;
  logic [10:0] secureTarget;
  int errTotal = 0, nChecks = 0, nSec = 0, nHard = 0, nLoad = 0;
  i2c_ctrl_model bm (.sys_clk, .busStart, .busStop, .rxStrobe, .rxByte, .txReq, .txByte);
  otp_stop_cmd dut (.sys_clk, .nrst, .busStart, .busStop, .rxStrobe, .rxByte, .txReq,
    .txByte, .addrAck, .hardwiredAddressBit, .coilFaultX, .coilFaultY, .otpAddrBits,
    .otpBytes, .securePosition, .secureAllowed, .motorMoving,
    .actualPosition, .shortStatusRead, .secureReq, .secureTarget, .hardStopReq,
    .targetLoad, .targetPosition, .stepLossFlag, .shutdownMode);
  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // pulses are counted so a test compares totals, not exact cycles
  always @(posedge sys_clk)
  begin
    nSec <= nSec + int'(secureReq === 1'b1);
    nHard <= nHard + int'(hardStopReq === 1'b1);
    nLoad <= nLoad + int'(targetLoad === 1'b1);
  end
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // own address is EA/EB, echo byte F5
  task automatic t_otp();
    bm.wframe(8'hEA, 8'h82);
    bm.edge_ev(1'b0);
    bm.put(8'hEB);
    tick(2);
    ck("ack", 1, addrAck);
    for (int i = 0; i < 8; i++)
    begin
      bm.get(rd);
      ck("tx", (i == 0) ? 8'hF5 : (i < 7) ? OTP[8*(i-1)+:8] : 8'hFF, rd);
    end
    bm.edge_ev(1'b1);
    bm.gap = 4;
    bm.edge_ev(1'b0);
    bm.put(8'hEB);
    bm.get(rd);
    ck("tx", 8'hFF, rd);
    bm.gap = 0;
    bm.edge_ev(1'b1);
    $display("otp test done");
  endtask
  task automatic t_secure();
    int s;
    s = nSec;
    bm.wframe(8'hEA, 8'h84);
    tick(3);
    ck("secTgt", 11'h5A3, secureTarget);
    // a new stored position must be followed by the next request
    securePosition <= 11'h2C7;
    bm.wframe(8'h00, 8'h84);
    tick(3);
    ck("sec", s + 2, nSec);
    ck("secTgt", 11'h2C7, secureTarget);
    secureAllowed <= 1'b0;
    bm.wframe(8'hEA, 8'h84);
    tick(3);
    ck("sec", s + 2, nSec);
    secureAllowed <= 1'b1;
    bm.edge_ev(1'b0);
    bm.put(8'h54);
    tick(2);
    ck("ack", 0, addrAck);
    bm.put(8'h85);
    bm.edge_ev(1'b1);
    bm.wframe(8'hEA, 8'h9F);
    bm.wframe(8'h00, 8'h85);
    tick(3);
    ck("hard", 0, nHard);
    // with the pin low the own address moves, so the old one is foreign
    hardwiredAddressBit <= 1'b0;
    bm.wframe(8'hEA, 8'h85);
    tick(3);
    ck("hard", 0, nHard);
    hardwiredAddressBit <= 1'b1;
    $display("secure test done");
  endtask
  task automatic t_stop();
    motorMoving <= 1'b1;
    bm.wframe(8'hEA, 8'h85);
    tick(3);
    ck("hard", 1, nHard);
    ck("loss", 1, stepLossFlag);
    ck("load", 0, nLoad);
    motorMoving <= 1'b0;
    tick(6);
    ck("load", 1, nLoad);
    ck("tgt", 16'h1234, targetPosition);
    shortStatusRead <= 1'b1;
    tick(1);
    shortStatusRead <= 1'b0;
    actualPosition <= 16'hFEDC;
    bm.wframe(8'hEA, 8'h85);
    tick(8);
    ck("loss", 0, stepLossFlag);
    ck("tgt", 16'hFEDC, targetPosition);
    $display("stop test done");
  endtask
  task automatic t_fault();
    coilFaultX <= 1'b1;
    coilFaultY <= 1'b1;
    tick(6);
    ck("shut", 1, shutdownMode);
    ck("hard", 3, nHard);
    coilFaultX <= 1'b0;
    coilFaultY <= 1'b0;
    bm.wframe(8'hEA, 8'h84);
    tick(3);
    ck("sec", 2, nSec);
    ck("shut", 1, shutdownMode);
    $display("fault test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errTotal++;
    conclude();
  end
  initial
  begin
    nrst <= 1'b0;
    hardwiredAddressBit <= 1'b1;
    coilFaultX <= 1'b0;
    coilFaultY <= 1'b0;
    secureAllowed <= 1'b1;
    motorMoving <= 1'b0;
    shortStatusRead <= 1'b0;
    actualPosition <= 16'h1234;
    otpAddrBits <= 4'hA;
    otpBytes <= OTP;
    securePosition <= 11'h5A3;
    tick(8);
    nrst <= 1'b1;
    tick(3);
    t_otp();
    t_secure();
    t_stop();
    t_fault();
    conclude();
  end
endmodule
